// *** hw/amc_pkg.sv ***
// Shared constants and types for the mode and calibration control block
package amc_pkg;
    localparam int WORD_W = 24;
    // Setup register field positions, most significant first
    localparam int MD_MSB = 23;
    localparam int MD_LSB = 21;
    localparam int GN_MSB = 20;
    localparam int GN_LSB = 18;
    localparam int CH_BIT = 17;
    localparam int PD_BIT = 16;
    localparam int WL_BIT = 15;
    localparam int RO_BIT = 14;
    localparam int BO_BIT = 13;
    localparam int BU_BIT = 12;
    localparam int FC_MSB = 11;
    // Value after reset: normal mode, every other field cleared
    localparam logic [23:0] SETUP_RST = 24'h000000;
    localparam logic [23:0] COEF_RST = 24'h000000;
    localparam logic [23:0] RESULT_RST = 24'h000000;
    // Serial word lengths in clocks
    localparam logic [4:0] LEN_SHORT = 5'h10;
    localparam logic [4:0] LEN_FULL = 5'h18;
    // Background slots: six samples per output word
    localparam logic [2:0] BG_SLOT_LAST = 3'h5;
    localparam logic [2:0] BG_SLOT_ZS = 3'h2;
    localparam logic [2:0] BG_SLOT_FS = 3'h4;
    localparam logic [2:0] BG_SLOT_REF0 = 3'h3;
    localparam logic [2:0] BG_SLOT_SH0 = 3'h1;

    typedef enum logic [2:0] {
        MD_NORM = 3'b000,
        MD_SELF = 3'b001,
        MD_SYS0 = 3'b010,
        MD_SYS1 = 3'b011,
        MD_OFS = 3'b100,
        MD_BG = 3'b101,
        MD_ZACC = 3'b110,
        MD_FACC = 3'b111
    } amc_mode_t;

    typedef enum logic [1:0] {
        ST_NORM = 2'b00,
        ST_ZS = 2'b01,
        ST_FS = 2'b10,
        ST_BG = 2'b11
    } amc_state_t;

    typedef enum logic [1:0] {
        AIN_CHAN = 2'b00,
        AIN_SHORT = 2'b01,
        AIN_REF = 2'b10
    } amc_ain_t;
endpackage

// *** hw/amc_lnk_if.sv ***
// Signals between the serial link domain and the system domain
`timescale 1ns/1ps
interface amc_lnk_if;
    logic [23:0] wr_word;
    logic wr_a0;
    logic wr_tgl;
    logic [23:0] rd_word;
    logic [4:0] rd_len;
    logic rd_tgl;
    modport lnk (output wr_word, wr_a0, wr_tgl, rd_tgl, input rd_word, rd_len);
    modport sys (input wr_word, wr_a0, wr_tgl, rd_tgl, output rd_word, rd_len);
endinterface

// *** hw/amc_coef_mem.sv ***
// Calibration coefficient store: two channels, zero-scale and full-scale
`timescale 1ns/1ps
module amc_coef_mem (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [1:0] waddr_i,
    input wire logic [23:0] wdata_i,
    input wire logic [1:0] raddr_i,
    output logic [23:0] rdata_o
);
    import amc_pkg::*;
    logic [23:0] mem_ff [4];
    logic [23:0] rdata_ff;

    // One word per entry, address {full_scale, channel}
    for (genvar i = 0; i < 4; i++)
    begin : g_ent
        always_ff @(posedge clk_sys_i or posedge rst_i)
        begin
            if (rst_i)
                mem_ff[i] <= COEF_RST;
            else if (we_i && waddr_i == 2'(i))
                mem_ff[i] <= wdata_i;
        end
    end

    // Registered read, one cycle of latency
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_ff <= COEF_RST;
        else
            rdata_ff <= mem_ff[raddr_i];
    end
    assign rdata_o = rdata_ff;
endmodule

// *** hw/amc_link.sv ***
// Serial port logic clocked by the host serial clock
`timescale 1ns/1ps
module amc_link (
    input wire logic sclk_i,
    input wire logic rst_i,
    input wire logic tfs_n_i,
    input wire logic rfs_n_i,
    input wire logic sdata_i,
    input wire logic register_select_pin_i,
    output logic sdata_o,
    output logic sdata_oe_n_o,
    amc_lnk_if.lnk bus
);
    import amc_pkg::*;
    logic [4:0] wcnt_ff, nxt_wcnt;
    logic [23:0] wsh_ff, nxt_wsh;
    logic [23:0] wword_ff, nxt_wword;
    logic wa0_ff, nxt_wa0;
    logic wtgl_ff, nxt_wtgl;
    logic [4:0] rcnt_ff, nxt_rcnt;
    logic rtgl_ff, nxt_rtgl;

    // Write shifter: only a full 24-bit word raises the event
    always_comb
    begin
        nxt_wcnt = wcnt_ff;
        nxt_wsh = wsh_ff;
        nxt_wword = wword_ff;
        nxt_wa0 = wa0_ff;
        nxt_wtgl = wtgl_ff;
        if (wcnt_ff != LEN_FULL)
        begin
            nxt_wsh = {wsh_ff[22:0], sdata_i};
            nxt_wcnt = wcnt_ff + 5'h01;
            if (wcnt_ff == LEN_FULL - 5'h01)
            begin
                nxt_wword = {wsh_ff[22:0], sdata_i};
                nxt_wa0 = register_select_pin_i;
                nxt_wtgl = ~wtgl_ff;
            end
        end
    end

    // Bit count is cleared by the frame pin itself, as the clock stops between frames
    always_ff @(posedge sclk_i or posedge rst_i or posedge tfs_n_i)
    begin
        if (rst_i || tfs_n_i)
            wcnt_ff <= 5'h00;
        else
            wcnt_ff <= nxt_wcnt;
    end

    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wsh_ff <= 24'h000000;
            wword_ff <= 24'h000000;
            wa0_ff <= 1'b0;
            wtgl_ff <= 1'b0;
            rtgl_ff <= 1'b0;
        end
        else
        begin
            wsh_ff <= nxt_wsh;
            wword_ff <= nxt_wword;
            wa0_ff <= nxt_wa0;
            wtgl_ff <= nxt_wtgl;
            rtgl_ff <= nxt_rtgl;
        end
    end

    // Read counter: stops at the word length, toggles once when done
    always_comb
    begin
        nxt_rcnt = rcnt_ff;
        nxt_rtgl = rtgl_ff;
        if (!rfs_n_i && rcnt_ff < bus.rd_len)
        begin
            nxt_rcnt = rcnt_ff + 5'h01;
            if (rcnt_ff == bus.rd_len - 5'h01)
                nxt_rtgl = ~rtgl_ff;
        end
    end

    always_ff @(posedge sclk_i or posedge rst_i or posedge rfs_n_i)
    begin
        if (rst_i || rfs_n_i)
            rcnt_ff <= 5'h00;
        else
            rcnt_ff <= nxt_rcnt;
    end

    // MSB first from the frozen snapshot; clocks past a 24-bit word read zero, past a 16-bit word repeat bit 7
    assign sdata_o = (rcnt_ff < LEN_FULL) ? bus.rd_word[5'h17 - rcnt_ff] : 1'b0;
    assign sdata_oe_n_o = rfs_n_i;
    assign bus.wr_word = wword_ff;
    assign bus.wr_a0 = wa0_ff;
    assign bus.wr_tgl = wtgl_ff;
    assign bus.rd_tgl = rtgl_ff;
endmodule

// *** hw/amc_ctrl.sv ***
// Operating mode decode, calibration sequencing and serial access steering
`timescale 1ns/1ps
module amc_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic tfs_n_i,
    input wire logic rfs_n_i,
    input wire logic register_select_pin_i,
    input wire logic sdata_i,
    output logic sdata_o,
    output logic sdata_oe_n_o,
    output logic data_ready_n_o,
    input wire logic [23:0] sample_i,
    input wire logic sample_valid_i,
    output amc_pkg::amc_ain_t ain_sel_o,
    output logic [2:0] operating_mode_field_o,
    output logic [2:0] gain_code_o,
    output logic input_select_o,
    output logic sleep_request_o,
    output logic result_length_sel_o,
    output logic excitation_on_o,
    output logic burnout_source_on_o,
    output logic unipolar_o,
    output logic [11:0] filter_code_o
);
    import amc_pkg::*;

    amc_lnk_if lnk_bus ();

    logic a0_m_ff, a0_s_ff, rfs_m_ff, rfs_s_ff;
    logic wtg_m_ff, wtg_s_ff, wtg_d_ff;
    logic rtg_m_ff, rtg_s_ff, rtg_d_ff;
    logic wr_evt, rd_evt;
    logic [23:0] setup_ff, nxt_setup;
    amc_state_t st_ff, nxt_st;
    logic [2:0] slot_ff, nxt_slot;
    logic [23:0] result_ff, nxt_result;
    logic data_ready_n_n_ff, nxt_data_ready_n_n;
    logic [23:0] snap_ff, nxt_snap;
    logic [4:0] snap_len_ff, nxt_snap_len;
    logic snap_dat_ff, nxt_snap_dat;
    logic data_ready_n_set, cal_done, cal_start;
    logic mem_we;
    logic [1:0] mem_waddr, mem_raddr;
    logic [23:0] mem_wdata, mem_rdata;
    amc_mode_t mode;
    logic ch;
    amc_ain_t ain;

    amc_link u_link (
        .sclk_i(sclk_i),
        .rst_i(rst_i),
        .tfs_n_i(tfs_n_i),
        .rfs_n_i(rfs_n_i),
        .sdata_i(sdata_i),
        .register_select_pin_i(register_select_pin_i),
        .sdata_o(sdata_o),
        .sdata_oe_n_o(sdata_oe_n_o),
        .bus(lnk_bus.lnk)
    );

    amc_coef_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    // Pin and toggle synchronisers; the second stage is looked at, and for the toggles also a third stage for edge detection
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            a0_m_ff <= 1'b0;
            a0_s_ff <= 1'b0;
            rfs_m_ff <= 1'b1;
            rfs_s_ff <= 1'b1;
            wtg_m_ff <= 1'b0;
            wtg_s_ff <= 1'b0;
            wtg_d_ff <= 1'b0;
            rtg_m_ff <= 1'b0;
            rtg_s_ff <= 1'b0;
            rtg_d_ff <= 1'b0;
        end
        else
        begin
            a0_m_ff <= register_select_pin_i;
            a0_s_ff <= a0_m_ff;
            rfs_m_ff <= rfs_n_i;
            rfs_s_ff <= rfs_m_ff;
            wtg_m_ff <= lnk_bus.wr_tgl;
            wtg_s_ff <= wtg_m_ff;
            wtg_d_ff <= wtg_s_ff;
            rtg_m_ff <= lnk_bus.rd_tgl;
            rtg_s_ff <= rtg_m_ff;
            rtg_d_ff <= rtg_s_ff;
        end
    end

    assign wr_evt = wtg_s_ff ^ wtg_d_ff;
    assign rd_evt = rtg_s_ff ^ rtg_d_ff;
    assign mode = amc_mode_t'(setup_ff[MD_MSB:MD_LSB]);
    assign ch = setup_ff[CH_BIT];

    // Analog input steering for the step in progress
    always_comb
    begin
        ain = AIN_CHAN;
        if (st_ff == ST_ZS && mode == MD_SELF)
            ain = AIN_SHORT;
        else if (st_ff == ST_FS && (mode == MD_SELF || mode == MD_OFS))
            ain = AIN_REF;
        else if (st_ff == ST_BG && (slot_ff == BG_SLOT_SH0 || slot_ff == BG_SLOT_ZS))
            ain = AIN_SHORT;
        else if (st_ff == ST_BG && (slot_ff == BG_SLOT_REF0 || slot_ff == BG_SLOT_FS))
            ain = AIN_REF;
    end

    // Mode sequencer, host writes and coefficient updates
    always_comb
    begin
        nxt_setup = setup_ff;
        nxt_st = st_ff;
        nxt_slot = slot_ff;
        nxt_result = result_ff;
        data_ready_n_set = 1'b0;
        cal_done = 1'b0;
        cal_start = 1'b0;
        mem_we = 1'b0;
        mem_waddr = {1'b0, ch};
        mem_wdata = sample_i;
        if (wr_evt && !lnk_bus.wr_a0)
            nxt_setup = lnk_bus.wr_word;
        else if (wr_evt && (mode == MD_ZACC || mode == MD_FACC))
        begin
            mem_we = 1'b1;
            mem_waddr = {mode == MD_FACC, ch};
            mem_wdata = lnk_bus.wr_word;
        end
        case (st_ff)
            ST_NORM:
            begin
                if (sample_valid_i && mode == MD_NORM)
                begin
                    nxt_result = sample_i;
                    data_ready_n_set = 1'b1;
                end
                case (mode)
                    MD_SELF, MD_SYS0, MD_OFS:
                    begin
                        nxt_st = ST_ZS;
                        cal_start = 1'b1;
                    end
                    MD_SYS1:
                    begin
                        nxt_st = ST_FS;
                        cal_start = 1'b1;
                    end
                    MD_BG:
                    begin
                        nxt_st = ST_BG;
                        nxt_slot = 3'h0;
                    end
                    default:
                    begin
                    end
                endcase
            end
            ST_ZS:
            begin
                // A mode rewrite mid-step abandons the calibration
                if (mode != MD_SELF && mode != MD_SYS0 && mode != MD_OFS)
                    nxt_st = ST_NORM;
                else if (sample_valid_i)
                begin
                    mem_we = 1'b1;
                    mem_waddr = {1'b0, ch};
                    mem_wdata = sample_i;
                    if (mode == MD_SYS0)
                        cal_done = 1'b1;
                    else
                        nxt_st = ST_FS;
                end
            end
            ST_FS:
            begin
                if (mode != MD_SELF && mode != MD_SYS1 && mode != MD_OFS)
                    nxt_st = ST_NORM;
                else if (sample_valid_i)
                begin
                    mem_we = 1'b1;
                    mem_waddr = {1'b1, ch};
                    mem_wdata = sample_i;
                    cal_done = 1'b1;
                end
            end
            ST_BG:
            begin
                if (mode != MD_BG)
                    nxt_st = ST_NORM;
                else if (sample_valid_i)
                begin
                    // Second sample after a switch is used, first lets the input settle
                    nxt_slot = (slot_ff == BG_SLOT_LAST) ? 3'h0 : slot_ff + 3'h1;
                    if (slot_ff == 3'h0)
                    begin
                        nxt_result = sample_i;
                        data_ready_n_set = 1'b1;
                    end
                    else if (slot_ff == BG_SLOT_ZS || slot_ff == BG_SLOT_FS)
                    begin
                        mem_we = 1'b1;
                        mem_waddr = {slot_ff == BG_SLOT_FS, ch};
                        mem_wdata = sample_i;
                    end
                end
            end
            default:
                nxt_st = ST_NORM;
        endcase
        if (cal_done)
        begin
            nxt_st = ST_NORM;
            nxt_setup[MD_MSB:MD_LSB] = MD_NORM;
            data_ready_n_set = 1'b1;
        end
    end

    // Ready: a new word wins over a read finishing in the same cycle
    always_comb
    begin
        nxt_data_ready_n_n = data_ready_n_n_ff;
        if (data_ready_n_set)
            nxt_data_ready_n_n = 1'b0;
        else if (cal_start || (rd_evt && snap_dat_ff))
            nxt_data_ready_n_n = 1'b1;
    end

    // Read steering; the snapshot freezes while a read frame is open
    assign mem_raddr = {mode == MD_FACC, ch};
    always_comb
    begin
        nxt_snap = snap_ff;
        nxt_snap_len = snap_len_ff;
        nxt_snap_dat = snap_dat_ff;
        if (rfs_s_ff)
        begin
            if (!a0_s_ff)
            begin
                nxt_snap = setup_ff;
                nxt_snap_len = LEN_FULL;
                nxt_snap_dat = 1'b0;
            end
            else if (mode == MD_ZACC || mode == MD_FACC)
            begin
                nxt_snap = mem_rdata;
                nxt_snap_len = LEN_FULL;
                nxt_snap_dat = 1'b0;
            end
            else
            begin
                nxt_snap = result_ff;
                nxt_snap_len = setup_ff[WL_BIT] ? LEN_FULL : LEN_SHORT;
                nxt_snap_dat = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            setup_ff <= SETUP_RST;
            st_ff <= ST_NORM;
            slot_ff <= 3'h0;
            result_ff <= RESULT_RST;
            data_ready_n_n_ff <= 1'b1;
            snap_ff <= 24'h000000;
            snap_len_ff <= LEN_FULL;
            snap_dat_ff <= 1'b0;
        end
        else
        begin
            setup_ff <= nxt_setup;
            st_ff <= nxt_st;
            slot_ff <= nxt_slot;
            result_ff <= nxt_result;
            data_ready_n_n_ff <= nxt_data_ready_n_n;
            snap_ff <= nxt_snap;
            snap_len_ff <= nxt_snap_len;
            snap_dat_ff <= nxt_snap_dat;
        end
    end

    assign lnk_bus.rd_word = snap_ff;
    assign lnk_bus.rd_len = snap_len_ff;
    assign data_ready_n_o = data_ready_n_n_ff;
    assign ain_sel_o = ain;
    assign operating_mode_field_o = setup_ff[MD_MSB:MD_LSB];
    assign gain_code_o = setup_ff[GN_MSB:GN_LSB];
    assign input_select_o = ch;
    assign sleep_request_o = setup_ff[PD_BIT];
    assign result_length_sel_o = setup_ff[WL_BIT];
    assign excitation_on_o = setup_ff[RO_BIT];
    assign burnout_source_on_o = setup_ff[BO_BIT];
    assign unipolar_o = setup_ff[BU_BIT];
    assign filter_code_o = setup_ff[FC_MSB:0];

    // Checks on the sequencer and steering
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_cal_mode_clear: assert property (cal_done |=> operating_mode_field_o == 3'b000)
        else $error("mode not cleared after calibration");
    a_cal_ready_low: assert property (cal_done |=> !data_ready_n_o && st_ff == ST_NORM)
        else $error("ready not low after calibration");
    a_self_zero_short: assert property (
        st_ff == ST_ZS && mode == MD_SELF |-> ain_sel_o == AIN_SHORT)
        else $error("self zero step not on shorted input");
    a_sys_zero_input: assert property (
        st_ff == ST_ZS && mode != MD_SELF |-> ain_sel_o == AIN_CHAN)
        else $error("system zero step not on input");
    a_sys_full_input: assert property (
        st_ff == ST_FS && mode == MD_SYS1 |-> ain_sel_o == AIN_CHAN)
        else $error("system full step not on input");
    a_ofs_full_ref: assert property (
        st_ff == ST_FS && mode == MD_OFS && sample_valid_i
        |-> ain_sel_o == AIN_REF && mem_we && mem_waddr[1])
        else $error("offset full step wrong");
    a_bg_result_slot: assert property (
        st_ff == ST_BG && mode == MD_BG && sample_valid_i && slot_ff != 3'h0
        |=> $stable(result_ff))
        else $error("background result outside slot zero");
    a_bg_coef_update: assert property (
        st_ff == ST_BG && mode == MD_BG && sample_valid_i && slot_ff == BG_SLOT_ZS
        |-> mem_we && mem_waddr == {1'b0, ch} && ain_sel_o == AIN_SHORT)
        else $error("background zero update missing");
    a_coef_write: assert property (
        wr_evt && lnk_bus.wr_a0 && mode == MD_ZACC && st_ff == ST_NORM
        |-> mem_we && mem_waddr == {1'b0, ch})
        else $error("zero coefficient write missed");
    a_setup_write: assert property (
        wr_evt && !lnk_bus.wr_a0 && !cal_done |=> setup_ff == $past(lnk_bus.wr_word))
        else $error("setup write not applied");
    a_read_result: assert property (
        rfs_s_ff && a0_s_ff && mode == MD_NORM |=> snap_ff == $past(result_ff) && snap_dat_ff)
        else $error("normal read not steered to result");
    a_ready_rise: assert property (rd_evt && snap_dat_ff && !data_ready_n_set |=> data_ready_n_o)
        else $error("ready not high after read");

    c_self_done: cover property (st_ff == ST_FS && mode == MD_SELF && cal_done);
    c_bg_wrap: cover property (st_ff == ST_BG && slot_ff == BG_SLOT_LAST && sample_valid_i);
    c_coef_write: cover property (wr_evt && lnk_bus.wr_a0 && mode == MD_FACC);
    c_data_read: cover property (rd_evt && snap_dat_ff);
endmodule

// *** dv/amc_host.sv ***
// Host serial port model: framed word writes and reads on the link
`timescale 1ns/1ps
module amc_host (
    output logic sclk_o,
    output logic tfs_n_o,
    output logic rfs_n_o,
    output logic sdata_o,
    output logic a0_o,
    input wire logic sdata_i,
    output logic [23:0] rd_word_o,
    output logic rd_done_o
);
    // Link clock rests low between frames
    initial
    begin
        sclk_o = 1'b0;
        tfs_n_o = 1'b1;
        rfs_n_o = 1'b1;
        sdata_o = 1'b0;
        a0_o = 1'b0;
        rd_word_o = 24'h000000;
        rd_done_o = 1'b0;
    end

    // Write n clocks, MSB first; clocks past 24 carry junk that must be ignored
    task automatic wr(input logic a0, input logic [23:0] d, input int n);
        a0_o = a0;
        #100;
        tfs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdata_o = (i < 24) ? d[23-i] : ~sdata_o;
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        tfs_n_o = 1'b1;
        sdata_o = ~sdata_o; // Released line flips so stale data never matches
    endtask

    // Read n bits; a0 settles well before the frame so the snapshot is current
    task automatic rd(input logic a0, input int n);
        a0_o = a0;
        #100;
        rfs_n_o = 1'b0;
        rd_word_o = 24'h000000;
        #100;
        for (int i = 0; i < n; i++)
        begin
            rd_word_o[23-i] = sdata_i;
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        rfs_n_o = 1'b1;
        rd_done_o = 1'b1;
        #1 rd_done_o = 1'b0;
    endtask
endmodule

// *** dv/adc_mode_calibration_control_tb.sv ***
// Self-checking bench for mode decode, calibration and serial access steering
`timescale 1ns/1ps
module adc_mode_calibration_control_tb;
    import amc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic sample_valid_i = 1'b0;
    logic [23:0] sample_i = 24'h000000;
    logic sclk, tfs_n, rfs_n, host_sd, a0, dut_sdo, oe_n, data_ready_n_n, rd_done;
    logic [2:0] mode, gain;
    logic insel, sleep, wl, exc, bo, uni;
    logic [11:0] fc;
    logic [23:0] rd_word, w, k, z, f, nrd;
    amc_ain_t ain;
    wire logic sd_line = oe_n ? host_sd : dut_sdo;
    wire logic [23:0] fields = {mode, gain, insel, sleep, wl, exc, bo, uni, fc};
    logic [23:0] exp_q[$];
    int mismatches = 0;
    int tests_run = 0;

    amc_ctrl DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk), .tfs_n_i(tfs_n),
        .rfs_n_i(rfs_n), .register_select_pin_i(a0), .sdata_i(sd_line), .sdata_o(dut_sdo),
        .sdata_oe_n_o(oe_n), .data_ready_n_o(data_ready_n_n), .sample_i(sample_i),
        .sample_valid_i(sample_valid_i), .ain_sel_o(ain), .operating_mode_field_o(mode),
        .gain_code_o(gain), .input_select_o(insel), .sleep_request_o(sleep),
        .result_length_sel_o(wl), .excitation_on_o(exc), .burnout_source_on_o(bo),
        .unipolar_o(uni), .filter_code_o(fc));

    amc_host HOST (.sclk_o(sclk), .tfs_n_o(tfs_n), .rfs_n_o(rfs_n), .sdata_o(host_sd),
        .a0_o(a0), .sdata_i(sd_line), .rd_word_o(rd_word), .rd_done_o(rd_done));

    // System clock, 25 ns period
    always #12.5 clk_sys_i = ~clk_sys_i;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Each finished host read takes the oldest expectation off the queue
    always @(posedge rd_done)
    begin
        if (exp_q.size() == 0)
            chk(rd_word, 24'hxxxxxx, "read without expectation");
        else
            chk(rd_word, exp_q.pop_front(), "read word");
    end

    task automatic expect_rd(input logic sel, input logic [23:0] e, input int n);
        exp_q.push_back(e);
        HOST.rd(sel, n);
    endtask

    // Setup write, then time for the toggle crossing and one sequencer step
    task automatic setw(input logic [23:0] d);
        HOST.wr(1'b0, d, 24);
        repeat (8) @(posedge clk_sys_i);
    endtask

    task automatic smp(input logic [23:0] d);
        @(posedge clk_sys_i);
        sample_i <= d;
        sample_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        sample_valid_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask

    // Mux must point where the step expects before its sample is taken
    task automatic cal(input amc_ain_t a, input logic [23:0] d);
        chk({22'h0, ain}, {22'h0, a}, "analog mux");
        smp(d);
    endtask

    task automatic done_ok();
        chk({21'h0, mode}, 24'h000000, "mode after calibration");
        chk({23'h0, data_ready_n_n}, 24'h000000, "ready after calibration");
    endtask

    // Coefficient readback; length bit is 0 yet 24 bits must come back
    task automatic coefs(input logic [23:0] zv, input logic [23:0] fv);
        setw(sw(3'b110));
        expect_rd(1'b1, zv, 24);
        setw(sw(3'b111));
        expect_rd(1'b1, fv, 24);
    endtask

    // Second input selected, 16-bit results, filter code nonzero
    function automatic logic [23:0] sw(input logic [2:0] m);
        return {m, 21'h020013};
    endfunction

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected run of about 115 us
    initial
    begin
        #2000000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h71fc));
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk(fields, SETUP_RST, "fields after reset");
        chk({23'h0, data_ready_n_n}, 24'h000001, "ready after reset");
        w = {3'b000, 21'($urandom())};
        setw(w);
        chk(fields, w, "setup fields");
        expect_rd(1'b0, w, 24);
        HOST.wr(1'b0, ~w, 16);
        repeat (8) @(posedge clk_sys_i);
        chk(fields, w, "short setup write");
        w = {3'b000, 21'($urandom())};
        HOST.wr(1'b0, w, 30);
        repeat (8) @(posedge clk_sys_i);
        chk(fields, w, "overlong setup write");
        z = $urandom();
        f = $urandom();
        setw(sw(3'b001));
        cal(AIN_SHORT, z);
        cal(AIN_REF, f);
        done_ok();
        coefs(z, f);
        z = $urandom();
        f = $urandom();
        setw(sw(3'b010));
        cal(AIN_CHAN, z);
        done_ok();
        setw(sw(3'b011));
        cal(AIN_CHAN, f);
        done_ok();
        coefs(z, f);
        z = $urandom();
        f = $urandom();
        setw(sw(3'b100));
        cal(AIN_CHAN, z);
        cal(AIN_REF, f);
        done_ok();
        coefs(z, f);
        w = $urandom();
        HOST.wr(1'b1, w, 24);
        HOST.wr(1'b1, ~w, 16);
        repeat (8) @(posedge clk_sys_i);
        chk(fields, sw(3'b111), "setup kept on select-high write");
        expect_rd(1'b1, w, 24);
        setw(sw(3'b110));
        HOST.wr(1'b1, ~w, 24);
        repeat (8) @(posedge clk_sys_i);
        expect_rd(1'b1, ~w, 24);
        setw(sw(3'b000));
        // Ready is still low from the calibration; a data read must raise it first
        expect_rd(1'b1, RESULT_RST, 16);
        repeat (8) @(posedge clk_sys_i);
        chk({23'h0, data_ready_n_n}, 24'h000001, "ready before new result");
        k = $urandom();
        smp(k);
        chk({23'h0, data_ready_n_n}, 24'h000000, "ready on new result");
        expect_rd(1'b1, {k[23:8], 8'h00}, 16);
        repeat (8) @(posedge clk_sys_i);
        chk({23'h0, data_ready_n_n}, 24'h000001, "ready after result read");
        setw(sw(3'b101));
        k = $urandom();
        nrd = 24'h000000;
        repeat (12)
        begin
            smp(k);
            if (data_ready_n_n === 1'b0)
            begin
                expect_rd(1'b1, {k[23:8], 8'h00}, 16);
                nrd++;
                repeat (8) @(posedge clk_sys_i);
            end
        end
        chk(nrd, 24'h000002, "results per twelve samples");
        coefs(k, k);
        end_of_test();
    end
endmodule
